// ---- design/cpm_param_map.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cpm_map.svh"

// Contract
// - writes to control data codes answer error
// - combined read returns value, setpoint, output
// - option status reads as eight flag bits
// - software type and version are read-only
// - fault flags use the listed bit weights
// - any fault flag write clears all bits except those whose condition is still present
// - emergency manual bit held during local manual
// - failsafe bit held while failsafe persists
// - factory calibration bit held while faulty
// - hardware bit on RAM or double fail
// - shed bit sticky until fault write
// - memory changed bit on shed, changes, toggles
// - separate checksum bits; recompute on status tests
// - setpoint count accepts only zero or one
// - readings reported in analog value format
module cpm_param_map
	import cpm_pkg::*;
#(
	parameter logic [7:0] SW_TYPE = 8'h5A, // arbitrary value
	parameter logic [7:0] SW_REV = 8'h01,
	parameter int NUM_INPUTS = 3
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic req_valid_i,
	input wire cpm_req_s req_i,
	output logic resp_valid_o,
	output cpm_resp_s resp_o,
	input wire logic [31:0] input1_i,
	input wire logic [31:0] input2_i,
	input wire logic [31:0] process_value_i,
	input wire logic [31:0] remote_variable_i,
	input wire logic [31:0] active_sp_i,
	input wire logic [31:0] output_val_i,
	input wire logic [7:0] option_flags_i,
	input wire logic emerg_manual_i,
	input wire logic failsafe_i,
	input wire logic work_cal_err_i,
	input wire logic cfg_sum_err_i,
	input wire logic factory_cal_err_i,
	input wire logic ram_test_fail_i,
	input wire logic conv_done_i,
	input wire logic [NUM_INPUTS-1:0] conv_fail_i,
	input wire logic shed_i,
	input wire logic cfg_changed_i,
	input wire logic status_test_i,
	output logic cksum_recompute_o,
	output logic [31:0] first_local_setpoint_o,
	output logic [31:0] second_local_setpoint_o,
	output logic [31:0] third_local_setpoint_o,
	output logic second_sp_enable_o,
	output logic [7:0] fault_flags_o
);

	cpm_resp_s next_resp;
	logic wr;
	logic first_sp_we, second_sp_we, third_sp_we;
	logic count_we;
	logic fault_clr;
	logic [7:0] setpoint_count_select;
	logic [4:0] low_cond;
	logic [4:0] prev_low_cond;
	logic low_change;
	logic [NUM_INPUTS-1:0] fail_twice;
	logic hw_fail;
	logic [7:0] fault_set;

	assign wr = req_valid_i & req_i.write;

	// request decode and answer
	always_comb begin
		next_resp = '0;
		unique case (req_i.code)
			`CPM_CODE_IN1, `CPM_CODE_IN2, `CPM_CODE_PROC_VAL, `CPM_CODE_REMOTE_VAR: begin
				next_resp.fmt = CPM_FMT_ANALOG;
				next_resp.error = req_i.write;
				unique case (req_i.code)
					`CPM_CODE_IN1: next_resp.d0 = input1_i;
					`CPM_CODE_IN2: next_resp.d0 = input2_i;
					`CPM_CODE_PROC_VAL: next_resp.d0 = process_value_i;
					default: next_resp.d0 = remote_variable_i;
				endcase
			end
			`CPM_CODE_COMBINED: begin
				next_resp.fmt = CPM_FMT_ANALOG;
				next_resp.error = req_i.write;
				next_resp.three = 1'b1;
				next_resp.d0 = process_value_i;
				next_resp.d1 = active_sp_i;
				next_resp.d2 = output_val_i;
			end
			`CPM_CODE_OPTIONS: begin
				next_resp.error = req_i.write;
				next_resp.d0 = {24'h000000, option_flags_i};
			end
			`CPM_CODE_SW_TYPE: begin
				next_resp.error = req_i.write;
				next_resp.d0 = {24'h000000, SW_TYPE};
			end
			`CPM_CODE_SW_REV: begin
				next_resp.error = req_i.write;
				next_resp.d0 = {24'h000000, SW_REV};
			end
			`CPM_CODE_FAULT: next_resp.d0 = {24'h000000, fault_flags_o};
			`CPM_CODE_FIRST_SP: begin
				next_resp.fmt = CPM_FMT_ANALOG;
				next_resp.d0 = req_i.write ? req_i.data : first_local_setpoint_o;
			end
			`CPM_CODE_SECOND_SP: begin
				next_resp.fmt = CPM_FMT_ANALOG;
				next_resp.d0 = req_i.write ? req_i.data : second_local_setpoint_o;
			end
			`CPM_CODE_THIRD_SP: begin
				next_resp.fmt = CPM_FMT_ANALOG;
				next_resp.d0 = req_i.write ? req_i.data : third_local_setpoint_o;
			end
			`CPM_CODE_SP_COUNT: begin
				next_resp.error = req_i.write && (req_i.data > 32'h0000_0001);
				next_resp.d0 = {24'h000000, setpoint_count_select};
			end
			default: next_resp.error = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			resp_valid_o <= 1'b0;
			resp_o <= '0;
		end else begin
			resp_valid_o <= req_valid_i;
			if (req_valid_i) begin
				resp_o <= next_resp;
			end
		end
	end

	assign first_sp_we = wr && (req_i.code == `CPM_CODE_FIRST_SP);
	assign second_sp_we = wr && (req_i.code == `CPM_CODE_SECOND_SP);
	assign third_sp_we = wr && (req_i.code == `CPM_CODE_THIRD_SP);
	assign count_we = wr && (req_i.code == `CPM_CODE_SP_COUNT) && !next_resp.error;

	// range limits of the first and second setpoint are held by the host, values are stored as given
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			first_local_setpoint_o <= `CPM_SP_RESET;
			second_local_setpoint_o <= `CPM_SP_RESET;
			third_local_setpoint_o <= `CPM_SP_RESET;
		end else begin
			if (first_sp_we) begin
				first_local_setpoint_o <= req_i.data;
			end
			if (second_sp_we) begin
				second_local_setpoint_o <= req_i.data;
			end
			if (third_sp_we) begin
				third_local_setpoint_o <= req_i.data;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			setpoint_count_select <= `CPM_SP_COUNT_RESET;
		end else if (count_we) begin
			setpoint_count_select <= req_i.data[7:0];
		end
	end

	assign second_sp_enable_o = (setpoint_count_select == `CPM_SP_COUNT_TWO);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cksum_recompute_o <= 1'b0;
		end else begin
			cksum_recompute_o <= status_test_i;
		end
	end

	genvar gi;
	for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
		cpm_fail_pair u_pair (
			.sys_clk_i(sys_clk_i),
			.rstn_i(rstn_i),
			.conv_done_i(conv_done_i),
			.fail_i(conv_fail_i[gi]),
			.fail_twice_o(fail_twice[gi])
		);
	end

	assign hw_fail = ram_test_fail_i | (|fail_twice);

	// condition levels behind the five lowest bits
	assign low_cond = {factory_cal_err_i, cfg_sum_err_i, work_cal_err_i, failsafe_i,
		emerg_manual_i};

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_low_cond <= 5'h00;
		end else begin
			prev_low_cond <= low_cond;
		end
	end

	assign low_change = |(low_cond ^ prev_low_cond);

	// bit weights of the fault flags
	always_comb begin
		fault_set = `CPM_FAULT_RESET;
		fault_set[`CPM_FAULT_EMERG] = emerg_manual_i;
		fault_set[`CPM_FAULT_FAILSAFE] = failsafe_i;
		fault_set[`CPM_FAULT_WORK_CAL] = work_cal_err_i;
		fault_set[`CPM_FAULT_CFG_SUM] = cfg_sum_err_i;
		fault_set[`CPM_FAULT_FACT_CAL] = factory_cal_err_i;
		fault_set[`CPM_FAULT_HW] = hw_fail;
		fault_set[`CPM_FAULT_SHED] = shed_i;
		fault_set[`CPM_FAULT_MEM_CHG] = shed_i | cfg_changed_i | low_change;
	end

	assign fault_clr = wr && (req_i.code == `CPM_CODE_FAULT);

	cpm_sticky #(
		.W(8)
	) u_fault (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.set_i(fault_set),
		.clr_i(fault_clr),
		.flags_o(fault_flags_o)
	);

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_ro_write_err: assert property (
		(req_valid_i && req_i.write && (req_i.code >= `CPM_CODE_IN1)
		&& (req_i.code <= `CPM_CODE_COMBINED)) |=> (resp_valid_o && resp_o.error))
		else $error("control data write not refused");

	a_combined_three: assert property (
		(req_valid_i && !req_i.write && (req_i.code == `CPM_CODE_COMBINED))
		|=> (resp_o.three && (resp_o.d0 == $past(process_value_i))
		&& (resp_o.d1 == $past(active_sp_i)) && (resp_o.d2 == $past(output_val_i))))
		else $error("combined read wrong");

	a_option_read: assert property (
		(req_valid_i && !req_i.write && (req_i.code == `CPM_CODE_OPTIONS))
		|=> (!resp_o.error && (resp_o.d0 == {24'h000000, $past(option_flags_i)})))
		else $error("option status read wrong");

	a_rev_read_only: assert property (
		(req_valid_i && (req_i.code == `CPM_CODE_SW_REV))
		|=> ((resp_o.error == $past(req_i.write)) && (resp_o.d0 == {24'h000000, SW_REV})))
		else $error("software version handling wrong");

	a_ident_write_err: assert property (
		(req_valid_i && req_i.write && ((req_i.code == `CPM_CODE_SW_TYPE)
		|| (req_i.code == `CPM_CODE_OPTIONS))) |=> resp_o.error)
		else $error("identity write not refused");

	a_fault_clear: assert property (
		(fault_clr && (fault_set == 8'h00)) |=> (fault_flags_o == 8'h00))
		else $error("fault flags not cleared");

	a_emerg_hold: assert property (
		emerg_manual_i [*2] |=> fault_flags_o[`CPM_FAULT_EMERG])
		else $error("emergency manual bit dropped");

	a_failsafe_hold: assert property (
		failsafe_i |=> fault_flags_o[`CPM_FAULT_FAILSAFE])
		else $error("failsafe bit dropped");

	a_factory_hold: assert property (
		factory_cal_err_i |=> fault_flags_o[`CPM_FAULT_FACT_CAL])
		else $error("factory calibration bit dropped");

	a_hw_fail_set: assert property (
		hw_fail |=> fault_flags_o[`CPM_FAULT_HW])
		else $error("hardware failure bit not set");

	a_shed_sticky: assert property (
		(fault_flags_o[`CPM_FAULT_SHED] && !fault_clr) |=> fault_flags_o[`CPM_FAULT_SHED])
		else $error("shed bit lost without write");

	a_mem_change: assert property (
		(shed_i || $changed(failsafe_i)) |=> fault_flags_o[`CPM_FAULT_MEM_CHG])
		else $error("memory changed bit not set");

	a_cksum_recompute: assert property (
		status_test_i |=> cksum_recompute_o)
		else $error("checksum recompute missing");

	a_count_legal: assert property (
		(req_valid_i && req_i.write && (req_i.code == `CPM_CODE_SP_COUNT)
		&& (req_i.data > 32'h0000_0001)) |=> (resp_o.error && $stable(second_sp_enable_o)))
		else $error("illegal setpoint count accepted");

	a_analog_fmt: assert property (
		(req_valid_i && (req_i.code == `CPM_CODE_PROC_VAL)) |=> (resp_o.fmt == CPM_FMT_ANALOG))
		else $error("reading not in analog format");

	c_combined_read: cover property (
		req_valid_i && !req_i.write && (req_i.code == `CPM_CODE_COMBINED));
	c_fault_clear: cover property (fault_clr && (fault_flags_o != 8'h00));
	c_sp2_enable: cover property (count_we && (req_i.data[7:0] == `CPM_SP_COUNT_TWO));
	c_double_fail: cover property (|fail_twice);

endmodule
`default_nettype wire

// ---- design/cpm_map.svh ----
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

// parameter identifying codes
`define CPM_CODE_FIRST_SP 8'h27
`define CPM_CODE_SECOND_SP 8'h35
`define CPM_CODE_THIRD_SP 8'h71
`define CPM_CODE_IN1 8'h76
`define CPM_CODE_IN2 8'h77
`define CPM_CODE_PROC_VAL 8'h78
`define CPM_CODE_REMOTE_VAR 8'h79
`define CPM_CODE_COMBINED 8'h7A
`define CPM_CODE_SW_TYPE 8'h9D
`define CPM_CODE_SW_REV 8'hA7
`define CPM_CODE_SP_COUNT 8'hAD
`define CPM_CODE_OPTIONS 8'hB9
`define CPM_CODE_FAULT 8'hFF

// fault flag bit positions
`define CPM_FAULT_EMERG 0
`define CPM_FAULT_FAILSAFE 1
`define CPM_FAULT_WORK_CAL 2
`define CPM_FAULT_CFG_SUM 3
`define CPM_FAULT_FACT_CAL 4
`define CPM_FAULT_HW 5
`define CPM_FAULT_SHED 6
`define CPM_FAULT_MEM_CHG 7

// setpoint count selections
`define CPM_SP_COUNT_ONE 8'h00
`define CPM_SP_COUNT_TWO 8'h01

// reset values
`define CPM_SP_RESET 32'h0000_0000
`define CPM_SP_COUNT_RESET 8'h00
`define CPM_FAULT_RESET 8'h00

`endif

// ---- design/cpm_pkg.sv ----
`default_nettype none
package cpm_pkg;

	typedef enum logic {
		CPM_FMT_DIGITAL = 1'b0,
		CPM_FMT_ANALOG = 1'b1
	} cpm_fmt_e;

	typedef struct packed {
		logic write;
		logic [7:0] code;
		logic [31:0] data;
	} cpm_req_s;

	typedef struct packed {
		logic error;
		cpm_fmt_e fmt;
		logic three;
		logic [31:0] d0;
		logic [31:0] d1;
		logic [31:0] d2;
	} cpm_resp_s;

endpackage
`default_nettype wire

// ---- design/cpm_sticky.sv ----
`timescale 1ns/10ps
`default_nettype none
// sticky flag bank, a set in the clearing cycle wins
module cpm_sticky #(
	parameter int W = 8
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] set_i,
	input wire logic clr_i,
	output logic [W-1:0] flags_o
);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags_o <= '0;
		end else if (clr_i) begin
			flags_o <= set_i;
		end else begin
			flags_o <= flags_o | set_i;
		end
	end

	a_set_wins: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i)))
		else $error("sticky flag lost a set");

endmodule
`default_nettype wire

// ---- design/cpm_fail_pair.sv ----
`timescale 1ns/10ps
`default_nettype none
// flags a failure on two consecutive conversions of one input
module cpm_fail_pair (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic conv_done_i,
	input wire logic fail_i,
	output logic fail_twice_o
);

	logic last_failed;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			last_failed <= 1'b0;
		end else if (conv_done_i) begin
			last_failed <= fail_i;
		end
	end

	assign fail_twice_o = conv_done_i & fail_i & last_failed;

endmodule
`default_nettype wire

// ---- testbench/cpm_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cpm_map.svh"

// host side: one request at a time, answer taken one cycle after the request
module cpm_host_model
	import cpm_pkg::*;
#(
	parameter logic [31:0] SP_LO = 32'h0000_0000,
	parameter logic [31:0] SP_HI = 32'h0000_FFFF
) (
	input wire logic sys_clk_i,
	output var logic req_valid_o,
	output var cpm_req_s req_o,
	input wire logic resp_valid_i,
	input wire cpm_resp_s resp_i
);
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
	end

	task automatic xfer(input logic wr, input logic [7:0] code, input logic [31:0] data,
			output cpm_resp_s resp, output logic ok);
		logic [31:0] d;
		d = data;
		if (wr && (code == `CPM_CODE_FIRST_SP || code == `CPM_CODE_SECOND_SP)) begin
			d = (data > SP_HI) ? SP_HI : ((data < SP_LO) ? SP_LO : data);
		end
		@(posedge sys_clk_i);
		req_valid_o <= 1'b1;
		req_o <= '{write: wr, code: code, data: d};
		@(posedge sys_clk_i);
		req_valid_o <= 1'b0;
		// released request lines show the inverse, not the last value
		req_o <= ~req_o;
		#1;
		ok = resp_valid_i;
		resp = resp_i;
	endtask
endmodule
`default_nettype wire

// ---- testbench/controller_parameter_map_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cpm_map.svh"

module controller_parameter_map_tb_top;
	import cpm_pkg::*;
	// arbitrary identity values
	localparam logic [7:0] TYP = 8'h3C;
	localparam logic [7:0] REV = 8'hC3;
	localparam logic [7:0] ROC [8] = '{`CPM_CODE_IN1, `CPM_CODE_IN2, `CPM_CODE_PROC_VAL,
		`CPM_CODE_REMOTE_VAR, `CPM_CODE_COMBINED, `CPM_CODE_SW_TYPE, `CPM_CODE_SW_REV,
		`CPM_CODE_OPTIONS};
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic req_valid;
	cpm_req_s req;
	logic resp_valid;
	cpm_resp_s resp;
	logic [31:0] rd [6] = '{default: 32'h0};
	logic [7:0] opt = 8'h00;
	logic [4:0] lvl = 5'h00;
	logic ram = 1'b0, conv_done = 1'b0, shed = 1'b0, cfg = 1'b0, stest = 1'b0;
	logic [2:0] cfail = 3'h0;
	logic cksum, sp2en;
	logic [31:0] first_sp, second_sp, third_sp;
	logic [7:0] flags;
	int fails = 0;
	int comparisons = 0;
	cpm_resp_s r;

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	cpm_host_model host (.sys_clk_i(sys_clk_i), .req_valid_o(req_valid), .req_o(req),
		.resp_valid_i(resp_valid), .resp_i(resp));

	cpm_param_map #(.SW_TYPE(TYP), .SW_REV(REV), .NUM_INPUTS(3)) DUT (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid), .req_i(req),
		.resp_valid_o(resp_valid), .resp_o(resp), .input1_i(rd[0]), .input2_i(rd[1]),
		.process_value_i(rd[2]), .remote_variable_i(rd[3]), .active_sp_i(rd[4]),
		.output_val_i(rd[5]),
		.option_flags_i(opt), .emerg_manual_i(lvl[0]), .failsafe_i(lvl[1]),
		.work_cal_err_i(lvl[2]), .cfg_sum_err_i(lvl[3]), .factory_cal_err_i(lvl[4]),
		.ram_test_fail_i(ram), .conv_done_i(conv_done), .conv_fail_i(cfail), .shed_i(shed),
		.cfg_changed_i(cfg), .status_test_i(stest), .cksum_recompute_o(cksum),
		.first_local_setpoint_o(first_sp), .second_local_setpoint_o(second_sp),
		.third_local_setpoint_o(third_sp), .second_sp_enable_o(sp2en), .fault_flags_o(flags));

	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	task automatic x(input logic wr, input logic [7:0] c, input logic [31:0] d, input logic er);
		logic ok;
		host.xfer(wr, c, d, r, ok);
		chk("resp_valid", 32'(1), 32'(ok));
		chk("error", 32'(er), 32'(r.error));
	endtask

	task automatic flt(input logic [7:0] e);
		x(1'b0, `CPM_CODE_FAULT, 32'h0, 1'b0);
		chk("fault read", 32'(e), r.d0);
		chk("fault port", 32'(e), 32'(flags));
	endtask

	function automatic logic [31:0] ev(input logic [7:0] c);
		case (c)
			`CPM_CODE_IN1: ev = rd[0];
			`CPM_CODE_IN2: ev = rd[1];
			`CPM_CODE_PROC_VAL, `CPM_CODE_COMBINED: ev = rd[2];
			`CPM_CODE_REMOTE_VAR: ev = rd[3];
			`CPM_CODE_SW_TYPE: ev = 32'(TYP);
			`CPM_CODE_SW_REV: ev = 32'(REV);
			default: ev = 32'(opt);
		endcase
	endfunction

	task automatic t_reads();
		for (int p = 0; p < 2; p++) begin
			@(posedge sys_clk_i);
			for (int k = 0; k < 6; k++) rd[k] <= {8'(p), 8'(k), 16'hBEEF};
			opt <= (p == 1) ? 8'hFF : 8'h00;
			for (int k = 0; k < 8; k++) begin
				x(1'b0, ROC[k], 32'h0, 1'b0);
				chk("read", ev(ROC[k]), r.d0);
				chk("three", 32'(ROC[k] == `CPM_CODE_COMBINED), 32'(r.three));
				if (k < 5) chk("fmt", 32'(CPM_FMT_ANALOG), 32'(r.fmt));
				if (k == 4) begin
					chk("sp", rd[4], r.d1);
					chk("out", rd[5], r.d2);
				end
			end
		end
	endtask

	task automatic t_ro_writes();
		for (int k = 0; k < 8; k++) begin
			x(1'b1, ROC[k], 32'hFFFF_FFFF, 1'b1);
			x(1'b0, ROC[k], 32'h0, 1'b0);
			chk("unchanged", ev(ROC[k]), r.d0);
		end
		x(1'b0, 8'h02, 32'h0, 1'b1);
	endtask

	task automatic t_setpoints();
		x(1'b1, `CPM_CODE_FIRST_SP, 32'h0000_1234, 1'b0);
		x(1'b1, `CPM_CODE_SECOND_SP, 32'h0000_FFFF, 1'b0);
		x(1'b1, `CPM_CODE_THIRD_SP, 32'h0000_ABCD, 1'b0);
		chk("first sp", 32'h0000_1234, first_sp);
		chk("second sp", 32'h0000_FFFF, second_sp);
		chk("third sp", 32'h0000_ABCD, third_sp);
		x(1'b0, `CPM_CODE_FIRST_SP, 32'h0, 1'b0);
		chk("first sp read", 32'h0000_1234, r.d0);
		x(1'b1, `CPM_CODE_SECOND_SP, 32'h0001_0000, 1'b0);
		chk("second sp limit", 32'h0000_FFFF, second_sp);
		x(1'b1, `CPM_CODE_SP_COUNT, 32'h1, 1'b0);
		chk("sp2 enable", 32'(1), 32'(sp2en));
		x(1'b1, `CPM_CODE_SP_COUNT, 32'h2, 1'b1);
		chk("sp2 enable", 32'(1), 32'(sp2en));
		x(1'b1, `CPM_CODE_SP_COUNT, 32'h0, 1'b0);
		chk("sp2 enable", 32'(0), 32'(sp2en));
	endtask

	task automatic conv(input logic [2:0] f);
		@(posedge sys_clk_i);
		conv_done <= 1'b1;
		cfail <= f;
		@(posedge sys_clk_i);
		conv_done <= 1'b0;
		cfail <= 3'h0;
		cyc(2);
	endtask

	task automatic t_faults();
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk_i);
			lvl <= 5'(1 << i);
			cyc(3);
			flt(8'(1 << i) | 8'h80);
			x(1'b1, `CPM_CODE_FAULT, 32'(i), 1'b0);
			flt(8'(1 << i));
			@(posedge sys_clk_i);
			lvl <= 5'h00;
			cyc(2);
			flt(8'(1 << i) | 8'h80);
			x(1'b1, `CPM_CODE_FAULT, 32'h0000_00FF, 1'b0);
			flt(8'h00);
		end
		@(posedge sys_clk_i);
		shed <= 1'b1;
		@(posedge sys_clk_i);
		shed <= 1'b0;
		cyc(8);
		flt(8'hC0);
		x(1'b1, `CPM_CODE_FAULT, 32'h0, 1'b0);
		@(posedge sys_clk_i);
		cfg <= 1'b1;
		@(posedge sys_clk_i);
		cfg <= 1'b0;
		ram <= 1'b1;
		@(posedge sys_clk_i);
		ram <= 1'b0;
		cyc(2);
		flt(8'hA0);
		x(1'b1, `CPM_CODE_FAULT, 32'h0, 1'b0);
		conv(3'b001);
		conv(3'b010);
		flt(8'h00);
		conv(3'b010);
		flt(8'h20);
		@(posedge sys_clk_i);
		stest <= 1'b1;
		@(posedge sys_clk_i);
		stest <= 1'b0;
		#1;
		chk("recompute", 32'(1), 32'(cksum));
		@(posedge sys_clk_i);
		#1;
		chk("recompute", 32'(0), 32'(cksum));
	endtask

	initial begin
		cyc(16);
		rstn_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk("reset flags", 32'h0, 32'(flags));
		chk("reset first sp", 32'h0, first_sp);
		chk("reset sp2 enable", 32'h0, 32'(sp2en));
		t_reads();
		t_ro_writes();
		t_setpoints();
		t_faults();
		conclude();
	end

	initial begin
		cyc(20000);
		fails++;
		conclude();
	end
endmodule
`default_nettype wire
